// [pkg/lcg_pkg.sv]
// Constants shared by the logic cell input gating block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package lcg_pkg;
  localparam int unsigned LCG_ADDR_W = 8;
  localparam logic [7:0] LCG_OFS_CH1_SEL = 8'h00;
  localparam logic [7:0] LCG_OFS_CH2_SEL = 8'h04;
  localparam logic [7:0] LCG_OFS_CH3_SEL = 8'h08;
  localparam logic [7:0] LCG_OFS_CH4_SEL = 8'h0c;
  localparam logic [7:0] LCG_OFS_GATE0_SEL = 8'h10;
  localparam logic [7:0] LCG_OFS_GATE1_SEL = 8'h14;
  localparam logic [7:0] LCG_OFS_GATE_POL = 8'h18;
  localparam logic [7:0] LCG_OFS_STATUS = 8'h1c;
  localparam int unsigned LCG_SEL_W = 6;
  localparam int unsigned LCG_GATE_W = 8;
  localparam int unsigned LCG_NUM_CH = 4;
  localparam logic [1:0] LCG_RESP_OKAY = 2'h0;
  localparam logic [1:0] LCG_RESP_SLVERR = 2'h2;
endpackage

// [tb/lcg_src_model.sv]
// Partner model: the peripheral and pin signals that feed the source bus.
// Assumes those sources are synchronous to aclk and change after its edge.
`timescale 1ns/1ns
`default_nettype none
module lcg_src_model #(
  parameter int unsigned NUM_SRC = 64
) (
  input wire logic aclk,
  input wire logic [NUM_SRC-1:0] pattern,
  output logic [NUM_SRC-1:0] source_bus
);
  // Each source takes its new level one edge after the bench asks for it.
  always_ff @(posedge aclk) begin
    source_bus <= pattern;
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the logic cell input gating block.
// Assumes the package is compiled first; the bench is the bus master.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lcg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [63:0] pattern = '0;
  logic [63:0] source_bus;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic chk = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, g0_out, g1_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] chans;
  logic [33:0] exp_q[$];
  int n_fail = 0;
  int check_count = 0;
  logic [5:0] sel[4];
  logic [7:0] gs[2];
  logic [1:0] pol;
  logic [5:0] last_out;

  // Free-running clock at 250 MHz.
  always #2 aclk = ~aclk;

  lcg_src_model #(.NUM_SRC(64)) lcg_src_model_inst (
    .aclk(aclk), .pattern(pattern), .source_bus(source_bus));

  lcg_top #(.NUM_SRC(64)) lcg_top_inst (
    .aclk(aclk), .aresetn(aresetn), .source_bus(source_bus),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_channels(chans),
    .gate0_out(g0_out), .gate1_out(g1_out));

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Takes the oldest note off the queue; an empty queue is a mismatch.
  task automatic pop(input logic [33:0] seen);
    if (exp_q.size() == 0) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, 34'h0);
    end else begin
      check(seen, exp_q.pop_front());
    end
  endtask

  // Compares every response and every probed output as it appears.
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      pop({32'h0, bresp});
    end
    if (rvalid && rready) begin
      pop({rdata, rresp});
    end
    if (chk) begin
      pop({28'h0, g1_out, g0_out, chans});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int k;
    exp_q.push_back({32'h0, r});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 40) begin
      n_fail++;
      results();
    end
  endtask

  // Writes random source codes, with junk in the upper bits, and the gates.
  task automatic setup(input logic [7:0] a, input logic [7:0] b,
                       input logic [1:0] p);
    logic [31:0] d;
    int i;
    for (i = 0; i < 4; i++) begin
      d = $urandom();
      sel[i] = d[5:0];
      wr(LCG_OFS_CH1_SEL + 8'(4 * i), d, LCG_RESP_OKAY);
    end
    gs[0] = a;
    gs[1] = b;
    pol = p;
    wr(LCG_OFS_GATE0_SEL, {24'h0, a}, LCG_RESP_OKAY);
    wr(LCG_OFS_GATE1_SEL, {24'h0, b}, LCG_RESP_OKAY);
    wr(LCG_OFS_GATE_POL, {30'h0, p}, LCG_RESP_OKAY);
  endtask

  // Applies a source pattern, lets it settle, then notes the expected outputs.
  task automatic probe(input logic [63:0] src);
    logic [3:0] ch;
    logic [1:0] g;
    int i;
    @(posedge aclk);
    pattern <= src;
    repeat (3) @(posedge aclk);
    for (i = 0; i < 4; i++) ch[i] = src[sel[i]];
    for (i = 0; i < 2; i++) g[i] = pol[i] ^ |(gs[i] & {ch[3], ~ch[3],
      ch[2], ~ch[2], ch[1], ~ch[1], ch[0], ~ch[0]});
    last_out = {g, ch};
    exp_q.push_back({28'h0, g, ch});
    chk <= 1'b1;
    @(posedge aclk);
    chk <= 1'b0;
  endtask

  task automatic readback();
    int i;
    for (i = 0; i < 4; i++) rd(LCG_OFS_CH1_SEL + 8'(4 * i),
      {26'h0, sel[i], LCG_RESP_OKAY});
    rd(LCG_OFS_GATE0_SEL, {24'h0, gs[0], LCG_RESP_OKAY});
    rd(LCG_OFS_GATE1_SEL, {24'h0, gs[1], LCG_RESP_OKAY});
    rd(LCG_OFS_STATUS, {26'h0, last_out, LCG_RESP_OKAY});
  endtask

  // Main sequence: term walk, unmapped access, then retention over reset.
  initial begin
    int t;
    void'($urandom(32'hbace779d));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (t = 0; t < 24; t++) begin
      if (t < 8) setup(8'h01 << t, 8'h80 >> t, 2'(t));
      else if (t == 8) setup(8'h00, 8'h00, 2'b00);
      else setup(8'($urandom()), 8'($urandom()), 2'($urandom()));
      probe({$urandom(), $urandom()});
      probe({$urandom(), $urandom()});
      readback();
    end
    $display("test terms done");
    wr(8'h20, 32'h0000_00ff, LCG_RESP_SLVERR);
    rd(8'h20, {32'h0, LCG_RESP_SLVERR});
    readback();
    $display("test unmapped done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    readback();
    probe({$urandom(), $urandom()});
    $display("test retain done");
    results();
  end
endmodule
`default_nettype wire

// [verilog/lcg_gate.sv]
// One gate of the logic cell: an OR of selected true and inverted channels.
// Assumes the term-select byte pairs channels as true on odd, inverted on even.
`timescale 1ns/1ns
`default_nettype none
module lcg_gate #(
  parameter int unsigned NUM_CH = 4
) (
  input wire logic [NUM_CH-1:0] channels,
  input wire logic [2*NUM_CH-1:0] term_select,
  input wire logic invert,
  output logic gate_out
);
  logic [2*NUM_CH-1:0] terms;

  // Expand each channel into its inverted (even) and true (odd) term.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      terms[2*i] = ~channels[i] & term_select[2*i];
      terms[2*i+1] = channels[i] & term_select[2*i+1];
    end
  end

  // A cleared select bit drops the term; no term gives zero before the invert.
  assign gate_out = (|terms) ^ invert; // [R05] [R06] [R07] [R08] [R09] [R10] [R11]
endmodule
`default_nettype wire

// [verilog/lcg_top.sv]
// Logic cell input selection and gate 0/1 term logic with AXI4-Lite registers.
// Assumes the source bus is synchronous to aclk; code mapping is external.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [R01] Channel 1 comes from the source picked by its 6-bit field.
// [R02] Channels 2 to 4 each come from their own 6-bit field.
// [R03] Selection register bits 7 and 6 store nothing and read zero.
// [R04] Configuration has no reset value; other resets leave it unchanged.
// [R05] Gate 0 odd bits admit true channels 4,3,2,1.
// [R06] Gate 0 even bits admit inverted channels 4,3,2,1.
// [R07] Gate 1 odd bits admit true channels 4,3,2,1.
// [R08] Gate 1 even bits admit inverted channels 4,3,2,1.
// [R09] A cleared select bit removes its term from the gate.
// [R10] A per-gate polarity bit inverts the gate output when set.
// [R11] Each gate ORs its admitted terms, zero when none admitted.
module lcg_top #(
  parameter int unsigned NUM_SRC = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_SRC-1:0] source_bus,
  input wire logic [lcg_pkg::LCG_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lcg_pkg::LCG_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] data_channels,
  output logic gate0_out,
  output logic gate1_out
);
  import lcg_pkg::*;

  initial begin
    if (NUM_SRC < 1 || NUM_SRC > 64) begin
      $error("NUM_SRC must be 1 to 64");
    end
  end

  // Configuration storage; deliberately outside the reset.
  logic [LCG_SEL_W-1:0] ch_source_field [LCG_NUM_CH];
  logic [LCG_GATE_W-1:0] gate_zero_term_select;
  logic [LCG_GATE_W-1:0] gate_one_term_select;
  logic [1:0] gate_output_invert;
  logic [LCG_SEL_W-1:0] next_ch_source_field [LCG_NUM_CH];
  logic [LCG_GATE_W-1:0] next_gate_zero_term_select;
  logic [LCG_GATE_W-1:0] next_gate_one_term_select;
  logic [1:0] next_gate_output_invert;

  // Bus handshake state.
  logic aw_held, w_held;
  logic [LCG_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held, next_w_held;
  logic [LCG_ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, write_hit;

  // Channel and gate datapath.
  logic [3:0] channels;
  logic [3:0] next_data_channels;
  logic gate0_comb, gate1_comb;

  // Select each channel from the source bus by its field.
  always_comb begin
    for (int c = 0; c < LCG_NUM_CH; c++) begin
      if (32'(ch_source_field[c]) < NUM_SRC) begin
        channels[c] = source_bus[ch_source_field[c]]; // [R01] [R02]
      end else begin
        channels[c] = 1'b0;
      end
    end
  end

  lcg_gate #(.NUM_CH(LCG_NUM_CH)) u_gate0 (
    .channels(channels),
    .term_select(gate_zero_term_select),
    .invert(gate_output_invert[0]),
    .gate_out(gate0_comb)
  );

  lcg_gate #(.NUM_CH(LCG_NUM_CH)) u_gate1 (
    .channels(channels),
    .term_select(gate_one_term_select),
    .invert(gate_output_invert[1]),
    .gate_out(gate1_comb)
  );

  assign next_data_channels = channels;

  // Outputs are registered one cycle after the channel and gate logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_channels <= 4'h0;
      gate0_out <= 1'b0;
      gate1_out <= 1'b0;
    end else begin
      data_channels <= next_data_channels;
      gate0_out <= gate0_comb;
      gate1_out <= gate1_comb;
    end
  end

  // Write channel: accept address and data in any order, then respond.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    write_hit = (aw_addr == LCG_OFS_CH1_SEL) || (aw_addr == LCG_OFS_CH2_SEL)
      || (aw_addr == LCG_OFS_CH3_SEL) || (aw_addr == LCG_OFS_CH4_SEL)
      || (aw_addr == LCG_OFS_GATE0_SEL) || (aw_addr == LCG_OFS_GATE1_SEL)
      || (aw_addr == LCG_OFS_GATE_POL) || (aw_addr == LCG_OFS_STATUS);
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = write_hit ? LCG_RESP_OKAY : LCG_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data, upper bits not stored.
  always_comb begin
    next_ch_source_field = ch_source_field;
    next_gate_zero_term_select = gate_zero_term_select;
    next_gate_one_term_select = gate_one_term_select;
    next_gate_output_invert = gate_output_invert;
    if (do_write && w_strb[0]) begin
      if (aw_addr == LCG_OFS_CH1_SEL) begin
        next_ch_source_field[0] = w_data[LCG_SEL_W-1:0]; // [R01] [R03]
      end else if (aw_addr == LCG_OFS_CH2_SEL) begin
        next_ch_source_field[1] = w_data[LCG_SEL_W-1:0]; // [R02] [R03]
      end else if (aw_addr == LCG_OFS_CH3_SEL) begin
        next_ch_source_field[2] = w_data[LCG_SEL_W-1:0]; // [R02] [R03]
      end else if (aw_addr == LCG_OFS_CH4_SEL) begin
        next_ch_source_field[3] = w_data[LCG_SEL_W-1:0]; // [R02] [R03]
      end else if (aw_addr == LCG_OFS_GATE0_SEL) begin
        next_gate_zero_term_select = w_data[LCG_GATE_W-1:0];
      end else if (aw_addr == LCG_OFS_GATE1_SEL) begin
        next_gate_one_term_select = w_data[LCG_GATE_W-1:0];
      end else if (aw_addr == LCG_OFS_GATE_POL) begin
        next_gate_output_invert = w_data[1:0]; // [R10]
      end
    end
  end

  // Configuration holds across bus reset; it is unknown at power-on.
  always_ff @(posedge aclk) begin
    ch_source_field <= next_ch_source_field; // [R04]
    gate_zero_term_select <= next_gate_zero_term_select; // [R04]
    gate_one_term_select <= next_gate_one_term_select;
    gate_output_invert <= next_gate_output_invert;
  end

  // Read channel: one read at a time, data zero-extended to 32 bits.
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = LCG_RESP_OKAY;
      next_rdata = 32'h0;
      if (s_axi_araddr == LCG_OFS_CH1_SEL) begin
        next_rdata = {26'h0, ch_source_field[0]}; // [R03]
      end else if (s_axi_araddr == LCG_OFS_CH2_SEL) begin
        next_rdata = {26'h0, ch_source_field[1]}; // [R03]
      end else if (s_axi_araddr == LCG_OFS_CH3_SEL) begin
        next_rdata = {26'h0, ch_source_field[2]}; // [R03]
      end else if (s_axi_araddr == LCG_OFS_CH4_SEL) begin
        next_rdata = {26'h0, ch_source_field[3]}; // [R03]
      end else if (s_axi_araddr == LCG_OFS_GATE0_SEL) begin
        next_rdata = {24'h0, gate_zero_term_select};
      end else if (s_axi_araddr == LCG_OFS_GATE1_SEL) begin
        next_rdata = {24'h0, gate_one_term_select};
      end else if (s_axi_araddr == LCG_OFS_GATE_POL) begin
        next_rdata = {30'h0, gate_output_invert};
      end else if (s_axi_araddr == LCG_OFS_STATUS) begin
        next_rdata = {26'h0, gate1_out, gate0_out, data_channels};
      end else begin
        next_rresp = LCG_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Bus registers; ready signals are registered and idle-high after reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Gate output follows its registered terms and polarity.
  gate_zero_track_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R05] [R06] [R09] [R11]
    gate0_out == $past(((|({channels, ~channels} & {gate_zero_term_select[7],
      gate_zero_term_select[5], gate_zero_term_select[3],
      gate_zero_term_select[1], gate_zero_term_select[6],
      gate_zero_term_select[4], gate_zero_term_select[2],
      gate_zero_term_select[0]}))) ^ gate_output_invert[0]))
    else $error("gate 0 output disagrees with its terms");
  gate_one_track_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R07] [R08] [R09] [R11]
    gate1_out == $past(((|({channels, ~channels} & {gate_one_term_select[7],
      gate_one_term_select[5], gate_one_term_select[3],
      gate_one_term_select[1], gate_one_term_select[6],
      gate_one_term_select[4], gate_one_term_select[2],
      gate_one_term_select[0]}))) ^ gate_output_invert[1]))
    else $error("gate 1 output disagrees with its terms");
  gate_none_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    ($past(gate_zero_term_select) == 8'h00 && !$past(gate_output_invert[0]))
      |-> !gate0_out)
    else $error("empty gate 0 is not zero");
  pol_invert_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    ($past(gate_zero_term_select) == 8'h00 && $past(gate_output_invert[0]))
      |-> gate0_out)
    else $error("gate 0 polarity not applied");
  ch_one_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
    (32'(ch_source_field[0]) < NUM_SRC) |=> data_channels[0] ==
      $past(source_bus[ch_source_field[0]]))
    else $error("channel 1 not routed from its source");
  ch_four_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
    (32'(ch_source_field[3]) < NUM_SRC) |=> data_channels[3] ==
      $past(source_bus[ch_source_field[3]]))
    else $error("channel 4 not routed from its source");
  sel_upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == LCG_OFS_CH1_SEL)
      |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0)
    else $error("selection upper bits not zero");
  cfg_hold_a: assert property (@(posedge aclk) // [R04]
    !$past(aresetn) && !$past(do_write) |->
      gate_one_term_select == $past(gate_one_term_select))
    else $error("configuration changed by reset");
  wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");

  write_gate0_c: cover property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == LCG_OFS_GATE0_SEL);
  read_status_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == LCG_OFS_STATUS);
  gate_toggle_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(gate1_out));
  bad_addr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bresp == LCG_RESP_SLVERR);
endmodule
`default_nettype wire
